// [design/tone_map_exchange.sv]
// Adaptive tone map exchange: neighbour table, request and response
`timescale 1ns/1ps
// Behaviour
// - Narrow band modulation code is two bits
// - Wide band code three bits, 4 to 7 reserved
// - Target minus level becomes 4-bit gain
// - Gain MSB zero raises, one lowers
// - Zero gain keeps previous transmit gain
// - Tone map bit per six-tone sub-band
// - Group coefficient 4 or 2 bits
// - Unimplemented group coefficients sent as zero
// - Link quality arrives from PHY indication
// - Received response updates or adds table entry; full table with no match drops it
// - No fresh record: request flag, robust
// - Fresh record: no request, stored parameters
// - Flag set: measure and return response
// - Flag clear: never send a response
// - Response always sent in robust mode
// - Decode data with header parameters
// - Response scheduled at earliest opportunity
// - Response reloads age and record fields
// - Record used until age reaches zero
// - Missing response: request again next frame
// - Requests only ride on outgoing data
// - Resolution bit: 6 dB or 3 dB
// - Wide band byte zero field layout
module tone_map_exchange
	import tone_map_pkg::*;
(
	input  wire logic                     i_clk,
	input  wire logic                     i_rstn,
	input  wire logic                     i_ce,
	// AXI4-Lite slave
	input  wire logic                     i_awvalid,
	output logic                          o_awready,
	input  wire logic [7:0]               i_awaddr,
	input  wire logic                     i_wvalid,
	output logic                          o_wready,
	input  wire logic [31:0]              i_wdata,
	input  wire logic [3:0]               i_wstrb,
	output logic                          o_bvalid,
	input  wire logic                     i_bready,
	output logic [1:0]                    o_bresp,
	input  wire logic                     i_arvalid,
	output logic                          o_arready,
	input  wire logic [7:0]               i_araddr,
	output logic                          o_rvalid,
	input  wire logic                     i_rready,
	output logic [31:0]                   o_rdata,
	output logic [1:0]                    o_rresp,
	// Outgoing data frame lookup
	input  wire logic                     i_tx_valid,
	input  wire logic [ADDR_W-1:0]        i_tx_dest,
	output logic                          o_tx_ready,
	output logic                          o_tx_cfg_valid,
	output tx_cfg_t                       o_tx_cfg,
	// Received data frame with PHY measurements
	input  wire logic                     i_rx_valid,
	input  wire logic [ADDR_W-1:0]        i_rx_src,
	input  wire logic                     i_rx_tone_map_request_flag,
	input  wire logic [2:0]               i_rx_fch_mod,
	input  wire logic [7:0]               i_rx_link_quality_value,
	input  wire logic [7:0]               i_rx_level,
	input  wire logic [TM_BITS-1:0]       i_rx_subband_ok,
	output logic                          o_rx_ready,
	output logic [2:0]                    o_rx_decode_mod,
	// Response to send
	output logic                          o_rsp_valid,
	input  wire logic                     i_rsp_ready,
	output logic [ADDR_W-1:0]             o_rsp_dest,
	output logic                          o_rsp_robust,
	output logic [8*RSP_BYTES-1:0]        o_rsp_body,
	// Response received from a peer
	input  wire logic                     i_rsp_in_valid,
	input  wire logic [ADDR_W-1:0]        i_rsp_in_src,
	input  wire logic [8*RSP_BYTES-1:0]   i_rsp_in_body
);
	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	logic [31:0]       ctrl_q;          // Band, resolution, target
	logic [15:0]       age_rld_q;       // Age reload value
	logic [15:0]       tick_div_q;      // Age tick interval
	logic [23:0]       lqth_q;          // Three quality thresholds
	logic [15:0]       req_cnt_q;       // Requests issued
	logic              us_band;         // Wide band selected
	logic              res_sel;         // Gain step resolution
	logic [7:0]        target_receive_level;
	assign us_band              = ctrl_q[CTRL_US_BIT];
	assign res_sel              = ctrl_q[CTRL_RES_BIT];
	assign target_receive_level = ctrl_q[CTRL_TGT_LSB +: 8];

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic              aw_q;            // Address held
	logic              w_q;             // Data held
	logic [7:0]        awaddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              wr_go;           // Both halves present
	logic              st_full;         // Table full flag
	logic [NUM_ENTRIES-1:0] st_valid;   // Occupied entries
	assign o_awready = i_ce && !aw_q && !o_bvalid;
	assign o_wready  = i_ce && !w_q && !o_bvalid;
	assign o_arready = i_ce && !o_rvalid;
	assign wr_go     = i_ce && aw_q && w_q && !o_bvalid;

	// Capture write address and data in either order
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			aw_q     <= 1'b0;
			w_q      <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end
		else if (i_ce)
		begin
			if (i_awvalid && o_awready)
			begin
				aw_q     <= 1'b1;
				awaddr_q <= i_awaddr;
			end
			else if (wr_go)
				aw_q <= 1'b0;
			if (i_wvalid && o_wready)
			begin
				w_q     <= 1'b1;
				wdata_q <= i_wdata;
				wstrb_q <= i_wstrb;
			end
			else if (wr_go)
				w_q <= 1'b0;
		end
	end

	// Byte-lane merge of a write into a register
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (be[b])
				r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction : merge

	// Register writes and write response
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			ctrl_q     <= CTRL_RST;
			age_rld_q  <= AGE_RST;
			tick_div_q <= TICK_RST;
			lqth_q     <= LQTH_RST;
			o_bvalid   <= 1'b0;
			o_bresp    <= AXI_OKAY;
		end
		else if (i_ce)
		begin
			if (wr_go)
			begin
				o_bvalid <= 1'b1;
				o_bresp  <= AXI_OKAY;
				case (awaddr_q)
					REG_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
					REG_AGE:  age_rld_q <=
						16'(merge({16'h0000, age_rld_q}, wdata_q, wstrb_q));
					REG_TICK: tick_div_q <=
						16'(merge({16'h0000, tick_div_q}, wdata_q, wstrb_q));
					REG_LQTH: lqth_q <=
						24'(merge({8'h00, lqth_q}, wdata_q, wstrb_q));
					REG_STATUS, REG_REQCNT: ;  // Read only, ignored
					default:  o_bresp <= AXI_DECERR;
				endcase
			end
			else if (i_bready)
				o_bvalid <= 1'b0;
		end
	end

	// Read data, one cycle after the address is taken
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			o_rvalid <= 1'b0;
			o_rdata  <= 32'h0000_0000;
			o_rresp  <= AXI_OKAY;
		end
		else if (i_ce)
		begin
			if (i_arvalid && o_arready)
			begin
				o_rvalid <= 1'b1;
				o_rresp  <= AXI_OKAY;
				o_rdata  <= 32'h0000_0000; // Unmapped reads return zero
				case (i_araddr)
					REG_CTRL:   o_rdata <= ctrl_q;
					REG_AGE:    o_rdata <= {16'h0000, age_rld_q};
					REG_TICK:   o_rdata <= {16'h0000, tick_div_q};
					REG_STATUS: o_rdata <= {27'h0, st_full, st_valid};
					REG_REQCNT: o_rdata <= {16'h0000, req_cnt_q};
					REG_LQTH:   o_rdata <= {8'h00, lqth_q};
					default:    o_rresp <= AXI_DECERR;
				endcase
			end
			else if (i_rready)
				o_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Neighbour table lookups
	// ------------------------------------------------------------
	nb_rec_t                tbl_q [NUM_ENTRIES];
	logic [NUM_ENTRIES-1:0] tx_hit;     // Destination match
	logic [NUM_ENTRIES-1:0] in_hit;     // Response source match
	genvar g;
	generate
		for (g = 0; g < NUM_ENTRIES; g++)
		begin : g_match
			assign tx_hit[g]   = tbl_q[g].valid &&
				tbl_q[g].addr == i_tx_dest;
			assign in_hit[g]   = tbl_q[g].valid &&
				tbl_q[g].addr == i_rsp_in_src;
			assign st_valid[g] = tbl_q[g].valid;
		end
	endgenerate
	assign st_full = &st_valid;

	// Pick the write slot: matching entry first, else first free
	logic                   wr_slot_ok;
	logic [1:0]             wr_slot;
	always_comb
	begin
		wr_slot_ok = 1'b0;
		wr_slot    = 2'h0;
		for (int e = NUM_ENTRIES - 1; e >= 0; e--)
			if (!tbl_q[e].valid)
			begin
				wr_slot_ok = 1'b1;
				wr_slot    = 2'(e);
			end
		for (int e = NUM_ENTRIES - 1; e >= 0; e--)
			if (in_hit[e])
			begin
				wr_slot_ok = 1'b1;
				wr_slot    = 2'(e);
			end
	end

	// ------------------------------------------------------------
	// Decode of a received response body
	// ------------------------------------------------------------
	logic [7:0]  in_b0;                 // Byte 0 of body
	mod_t        in_mod;
	logic        in_res;
	logic [3:0]  in_gain;
	logic [TM_BITS-1:0] in_tm;
	assign in_b0   = i_rsp_in_body[8*RSP_BYTES-1 -: 8];
	assign in_res  = in_b0[7];
	assign in_gain = in_b0[6:3];
	always_comb
	begin
		if (us_band)
		begin
			// Reserved codes fall back to robust
			in_mod = (in_b0[2:0] > 3'h3) ? MOD_ROBUST : mod_t'(in_b0[2:0]);
			in_tm  = i_rsp_in_body[8*RSP_BYTES-9 -: TM_BITS];
		end
		else
		begin
			in_mod = mod_t'({1'b0, in_b0[2:1]});
			in_tm  = {15'h0000, in_b0[0],
				i_rsp_in_body[8*RSP_BYTES-9 -: 8]};
		end
	end

	// ------------------------------------------------------------
	// Age tick divider
	// ------------------------------------------------------------
	logic [15:0] tick_cnt_q;
	logic        tick;
	assign tick = (tick_cnt_q >= tick_div_q); // Lowered interval acts at once
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			tick_cnt_q <= 16'h0000;
		else if (i_ce)
			tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
	end

	// Table writes and ageing; a fresh response wins over a tick
	generate
		for (g = 0; g < NUM_ENTRIES; g++)
		begin : g_entry
			always_ff @(posedge i_clk)
			begin
				if (!i_rstn)
					tbl_q[g] <= '0;
				else if (i_ce)
				begin
					// Full table and no match: store skipped
					if (i_rsp_in_valid && wr_slot_ok &&
						wr_slot == 2'(g))
					begin
						tbl_q[g].valid <= 1'b1;
						tbl_q[g].addr  <= i_rsp_in_src;
						tbl_q[g].mod   <= in_mod;
						tbl_q[g].gain_step_resolution <= in_res;
						tbl_q[g].gain_step_request    <= in_gain;
						tbl_q[g].subband_enable_bits  <= in_tm;
						tbl_q[g].age   <= age_rld_q;
					end
					else if (tick && tbl_q[g].age != 16'h0000)
						tbl_q[g].age <= tbl_q[g].age - 16'h0001;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Transmit lookup
	// ------------------------------------------------------------
	nb_rec_t hit_rec;                   // Matching record
	logic    hit_fresh;                 // Record present, not aged
	always_comb
	begin
		hit_rec = '0;
		for (int e = 0; e < NUM_ENTRIES; e++)
			if (tx_hit[e])
				hit_rec = tbl_q[e];
	end
	assign hit_fresh  = hit_rec.valid && hit_rec.age != 16'h0000;
	assign o_tx_ready = i_ce;

	// Only a data frame leads to a request
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			o_tx_cfg_valid <= 1'b0;
			o_tx_cfg       <= '0;
			req_cnt_q      <= 16'h0000;
		end
		else if (i_ce)
		begin
			o_tx_cfg_valid <= i_tx_valid;
			if (i_tx_valid && hit_fresh)
			begin
				o_tx_cfg.tone_map_request_flag <= 1'b0;
				o_tx_cfg.robust <= hit_rec.mod == MOD_ROBUST;
				o_tx_cfg.mod    <= hit_rec.mod;
				o_tx_cfg.gain_step_resolution <=
					hit_rec.gain_step_resolution;
				o_tx_cfg.gain_step_request <= hit_rec.gain_step_request;
				o_tx_cfg.subband_enable_bits <=
					hit_rec.subband_enable_bits;
			end
			else if (i_tx_valid)
			begin
				// Keeps asking until a response lands
				o_tx_cfg <= '0;
				o_tx_cfg.tone_map_request_flag <= 1'b1;
				o_tx_cfg.robust <= 1'b1;
				o_tx_cfg.mod    <= MOD_ROBUST;
				o_tx_cfg.subband_enable_bits <= '1;
				req_cnt_q <= req_cnt_q + 16'h0001;
			end
		end
	end

	// ------------------------------------------------------------
	// Response builder
	// ------------------------------------------------------------
	logic [8:0]  lvl_diff;              // Target minus level
	logic [7:0]  lvl_abs;
	logic [7:0]  steps;
	logic [2:0]  mag;
	logic [3:0]  gain_req;
	mod_t        pick_mod;
	logic [TM_BITS-1:0]   tm_new;
	logic [8*RSP_BYTES-1:0] body;
	assign lvl_diff = {1'b0, target_receive_level} - {1'b0, i_rx_level};
	assign lvl_abs  = lvl_diff[8] ? 8'(-lvl_diff) : lvl_diff[7:0];
	// Constant divisors keep the step count purely combinational
	assign steps    = res_sel ? 8'(lvl_abs / STEP_DB_3)
	                          : 8'(lvl_abs / STEP_DB_6);
	assign mag      = (steps > 8'(GAIN_MAG_MAX)) ? GAIN_MAG_MAX
	                                              : steps[2:0];
	// Sign in the top bit; zero keeps the gain
	assign gain_req = (mag == 3'h0) ? 4'h0 : {lvl_diff[8], mag};
	assign tm_new   = us_band ? i_rx_subband_ok
	                          : {15'h0000, i_rx_subband_ok[TM_BITS_EU-1:0]};

	// Quality thresholds choose the modulation
	always_comb
	begin
		if (i_rx_link_quality_value < lqth_q[7:0])
			pick_mod = MOD_ROBUST;
		else if (i_rx_link_quality_value < lqth_q[15:8])
			pick_mod = MOD_DBPSK;
		else if (i_rx_link_quality_value < lqth_q[23:16])
			pick_mod = MOD_DQPSK;
		else
			pick_mod = MOD_D8PSK;
	end

	// Pack per band; group coefficients left zero
	always_comb
	begin
		body = '0;
		if (us_band)
		begin
			body[95:88] = {res_sel, gain_req, pick_mod};
			body[87:64] = tm_new;
			body[63:56] = i_rx_link_quality_value;
		end
		else
		begin
			body[95:88] = {res_sel, gain_req, pick_mod[1:0],
				tm_new[8]};
			body[87:80] = tm_new[7:0];
			body[79:72] = i_rx_link_quality_value;
		end
	end

	// One response slot; a busy slot stalls the receive side
	assign o_rx_ready = i_ce && !o_rsp_valid;
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			o_rsp_valid     <= 1'b0;
			o_rsp_dest      <= '0;
			o_rsp_body      <= '0;
			o_rsp_robust    <= 1'b1;
			o_rx_decode_mod <= 3'h0;
		end
		else if (i_ce)
		begin
			if (i_rx_valid && o_rx_ready)
				o_rx_decode_mod <= i_rx_fch_mod;
			// Flag clear: nothing queued
			if (i_rx_valid && o_rx_ready && i_rx_tone_map_request_flag)
			begin
				o_rsp_valid  <= 1'b1;
				o_rsp_dest   <= i_rx_src;
				o_rsp_body   <= body;
				o_rsp_robust <= 1'b1;
			end
			else if (i_rsp_ready)
				o_rsp_valid <= 1'b0;
		end
	end
endmodule : tone_map_exchange

// [design/tone_map_pkg.sv]
// Package: constants, codes and carriers of the tone map exchange block
package tone_map_pkg;
	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00; // Band, resolution, target
	localparam logic [7:0] REG_AGE    = 8'h04; // Age reload value
	localparam logic [7:0] REG_TICK   = 8'h08; // Age tick interval
	localparam logic [7:0] REG_STATUS = 8'h0c; // Table occupancy
	localparam logic [7:0] REG_REQCNT = 8'h10; // Requests sent
	localparam logic [7:0] REG_LQTH   = 8'h14; // Modulation thresholds
	// Control fields
	localparam int CTRL_US_BIT  = 0;
	localparam int CTRL_RES_BIT = 1;
	localparam int CTRL_TGT_LSB = 8;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_8000;
	localparam logic [15:0] AGE_RST  = 16'h00ff;
	localparam logic [15:0] TICK_RST = 16'hffff;
	localparam logic [23:0] LQTH_RST = 24'hc0_80_40;
	// ------------------------------------------------------------
	// Sizes and codes
	// ------------------------------------------------------------
	localparam int NUM_ENTRIES = 4;      // Neighbour table depth
	localparam int ADDR_W      = 16;     // Station address width
	localparam int TM_BITS     = 24;     // Tone map bits, wide band
	localparam int TM_BITS_EU  = 9;      // Tone map bits, narrow band
	localparam int RSP_BYTES   = 12;     // Response body length
	localparam int STEP_DB_6   = 6;      // Gain step, resolution 0
	localparam int STEP_DB_3   = 3;      // Gain step, resolution 1
	localparam logic [2:0] GAIN_MAG_MAX = 3'h7;
	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_DECERR = 2'h3;
	typedef enum logic [2:0]
	{
		MOD_ROBUST = 3'h0,
		MOD_DBPSK  = 3'h1,
		MOD_DQPSK  = 3'h2,
		MOD_D8PSK  = 3'h3
	} mod_t;
	// Transmit configuration handed to the PHY and header builder
	typedef struct packed
	{
		logic               tone_map_request_flag;
		logic               robust;
		mod_t               mod;
		logic               gain_step_resolution;
		logic [3:0]         gain_step_request;
		logic [TM_BITS-1:0] subband_enable_bits;
	} tx_cfg_t;
	// One neighbour table record
	typedef struct packed
	{
		logic               valid;
		logic [ADDR_W-1:0]  addr;
		mod_t               mod;
		logic               gain_step_resolution;
		logic [3:0]         gain_step_request;
		logic [TM_BITS-1:0] subband_enable_bits;
		logic [15:0]        age;
	} nb_rec_t;
endpackage : tone_map_pkg

// [sim/test_tone_map_exchange.sv]
// Self-checking bench of the tone map exchange block
`timescale 1ns/1ps
module test_tone_map_exchange
	import tone_map_pkg::*;
;
	// ------------------------------------------------
	// Signals
	// ------------------------------------------------
	localparam tx_cfg_t REQ_CFG = {2'h3, MOD_ROBUST, 5'h00, 24'hffffff};
	localparam tx_cfg_t USE_CFG = {2'h0, MOD_DQPSK, 5'h03, 24'habcdef};
	localparam logic [95:0] PEER_BODY = {8'h1a, 24'habcdef, 8'h55, 56'h0};
	logic        i_clk, i_rstn = 1'h0, i_ce = 1'h1;
	logic        i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
	logic        i_arvalid = 1'h0, i_rready = 1'h0;
	logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
	logic [31:0] i_wdata = 32'h0, o_rdata;
	logic [3:0]  i_wstrb = 4'hf;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0]  o_bresp, o_rresp;
	logic        i_tx_valid = 1'h0, o_tx_ready, o_tx_cfg_valid;
	tx_cfg_t     o_tx_cfg;
	logic [15:0] i_tx_dest = 16'h0, i_rx_src = 16'h0, o_rsp_dest, i_rsp_in_src;
	logic        i_rx_valid = 1'h0, i_rx_tone_map_request_flag = 1'h0;
	logic [2:0]  i_rx_fch_mod = 3'h0, o_rx_decode_mod;
	logic [7:0]  i_rx_link_quality_value = 8'h0, i_rx_level = 8'h0;
	logic [23:0] i_rx_subband_ok = 24'h0001ff;
	logic        o_rx_ready, o_rsp_valid, i_rsp_ready, o_rsp_robust;
	logic        i_rsp_in_valid, mute = 1'h1, slow = 1'h0;
	logic [95:0] o_rsp_body, i_rsp_in_body;
	int          n_fail = 0, n_checks = 0;
	tone_map_exchange i_tone_map_exchange (.*);
	tone_map_peer_model i_tone_map_peer_model (.i_clk(i_clk),
		.i_rstn(i_rstn), .i_cfg_valid(o_tx_cfg_valid), .i_cfg(o_tx_cfg),
		.i_dest(i_tx_dest), .i_mute(mute), .i_slow(slow),
		.i_body(PEER_BODY), .i_rsp_valid(o_rsp_valid),
		.o_rsp_ready(i_rsp_ready), .o_in_valid(i_rsp_in_valid),
		.o_in_src(i_rsp_in_src), .o_in_body(i_rsp_in_body));
	// ------------------------------------------------
	// Shared tasks
	// ------------------------------------------------
	task automatic chk(input string what, input logic [95:0] e, g);
		n_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	// One bus cycle; ready is judged at the falling edge before the take
	task automatic axi(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
		logic ta, tw, tr;
		int n;
		n = 0;
		@(posedge i_clk);
		i_awvalid <= wr;
		i_wvalid <= wr;
		i_bready <= wr;
		i_arvalid <= !wr;
		i_rready <= !wr;
		i_awaddr <= a;
		i_araddr <= a;
		i_wdata <= d;
		do
		begin
			@(negedge i_clk);
			ta = i_awvalid && o_awready || i_arvalid && o_arready;
			tw = i_wvalid && o_wready;
			tr = i_bready && o_bvalid || i_rready && o_rvalid;
			q = o_rdata;
			r = wr ? o_bresp : o_rresp;
			@(posedge i_clk);
			n++;
			if (ta)
			begin
				i_awvalid <= 1'h0;
				i_arvalid <= 1'h0;
			end
			if (tw)
				i_wvalid <= 1'h0;
			if (tr)
			begin
				i_bready <= 1'h0;
				i_rready <= 1'h0;
			end
		end while (!tr && n < 100);
		chk("bus_answer", 1, tr);
	endtask : axi
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic [31:0] q;
		logic [1:0] r;
		axi(1'h0, a, 32'h0, q, r);
		chk("rdata", e, q);
		chk("rresp", er, r);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic [31:0] q;
		logic [1:0] r;
		axi(1'h1, a, d, q, r);
		chk("bresp", er, r);
	endtask : wr
	// Lookup for one outgoing frame, compared with the expected set
	task automatic tx(input logic [15:0] d, input tx_cfg_t e);
		@(posedge i_clk);
		i_tx_valid <= 1'h1;
		i_tx_dest <= d;
		@(posedge i_clk);
		i_tx_valid <= 1'h0;
		@(negedge i_clk);
		chk("cfg_valid", 1, o_tx_cfg_valid);
		chk("tx_cfg", e, o_tx_cfg);
		chk("tx_ready", 1, o_tx_ready);
	endtask : tx
	// Received frame; a response must follow only when asked for
	task automatic rx(input logic f, input logic [2:0] m,
		input logic [7:0] lv, lq, input logic [95:0] eb);
		int n;
		@(posedge i_clk);
		i_rx_valid <= 1'h1;
		i_rx_tone_map_request_flag <= f;
		i_rx_fch_mod <= m;
		i_rx_level <= lv;
		i_rx_link_quality_value <= lq;
		i_rx_src <= i_rx_src + 16'h1;
		@(posedge i_clk);
		i_rx_valid <= 1'h0;
		i_rx_level <= ~lv;
		i_rx_link_quality_value <= ~lq;
		@(negedge i_clk);
		chk("rsp_valid", f, o_rsp_valid);
		chk("decode_mod", m, o_rx_decode_mod);
		if (f)
			chk("rsp_body", eb, o_rsp_body);
		for (n = 0; n < 20 && o_rsp_valid; n++)
			@(negedge i_clk);
		chk("rsp_drop", 0, o_rsp_valid);
	endtask : rx
	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	task automatic t_regs();
		rd(REG_CTRL, CTRL_RST, AXI_OKAY);
		rd(REG_AGE, {16'h0, AGE_RST}, AXI_OKAY);
		rd(REG_TICK, {16'h0, TICK_RST}, AXI_OKAY);
		rd(REG_REQCNT, 32'h0, AXI_OKAY);
		rd(REG_LQTH, {8'h0, LQTH_RST}, AXI_OKAY);
		rd(8'h40, 32'h0, AXI_DECERR);
		wr(8'h40, 32'h1, AXI_DECERR);
		wr(REG_STATUS, 32'h1f, AXI_OKAY);
		rd(REG_STATUS, 32'h0, AXI_OKAY);
	endtask : t_regs
	// Silent peer: every frame asks again, in robust mode
	task automatic t_req();
		tx(16'h00a1, REQ_CFG);
		tx(16'h00a1, REQ_CFG);
		rd(REG_REQCNT, 32'h2, AXI_OKAY);
	endtask : t_req
	task automatic t_use();
		wr(REG_CTRL, 32'h8001, AXI_OKAY);
		mute <= 1'h0;
		tx(16'h00a1, REQ_CFG);
		repeat (8) @(posedge i_clk);
		tx(16'h00a1, USE_CFG);
		rd(REG_STATUS, 32'h1, AXI_OKAY);
	endtask : t_use
	// Short age: record used, expires, asked again; then the table fills
	task automatic t_age();
		wr(REG_AGE, 32'h8, AXI_OKAY);
		wr(REG_TICK, 32'h3, AXI_OKAY);
		tx(16'h00b2, REQ_CFG);
		repeat (8) @(posedge i_clk);
		tx(16'h00b2, USE_CFG);
		repeat (60) @(posedge i_clk);
		tx(16'h00b2, REQ_CFG);
		for (int k = 3; k < 6; k++)
		begin
			tx(16'h00a0 + 16'(k), REQ_CFG);
			repeat (8) @(posedge i_clk);
		end
		rd(REG_STATUS, 32'h1f, AXI_OKAY);
		tx(16'h00a5, REQ_CFG);
	endtask : t_age
	task automatic t_rx();
		slow <= 1'h1;
		for (int m = 0; m < 4; m++)
			rx(1'h0, m[2:0], 8'h80, 8'h50, 96'h0);
		rx(1'h1, 3'h0, 8'h74, 8'h50, {8'h11, 24'h0001ff, 8'h50, 56'h0});
		wr(REG_CTRL, 32'h8003, AXI_OKAY);
		rx(1'h1, 3'h3, 8'h89, 8'hd0, {8'hdb, 24'h0001ff, 8'hd0, 56'h0});
		wr(REG_CTRL, 32'h8000, AXI_OKAY);
		rx(1'h1, 3'h1, 8'h82, 8'h90, {8'h05, 8'hff, 8'h90, 72'h0});
		wr(REG_CTRL, 32'h8001, AXI_OKAY);
		rx(1'h1, 3'h2, 8'h80, 8'h10, {8'h00, 24'h0001ff, 8'h10, 56'h0});
	endtask : t_rx
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude
	// ------------------------------------------------
	// Clock, sequence and watchdog
	// ------------------------------------------------
	initial
	begin
		i_clk = 1'h0;
		forever #2 i_clk = ~i_clk;
	end
	initial
	begin
		repeat (10) @(posedge i_clk);
		i_rstn <= 1'h1;
		t_regs();
		t_req();
		t_use();
		t_age();
		t_rx();
		conclude();
	end
	// Whole run is near 250 cycles; five thousand means a hang
	initial
	begin
		repeat (5000) @(posedge i_clk);
		n_fail++;
		conclude();
	end
endmodule : test_tone_map_exchange

// [sim/tone_map_exchange_monitor.sv]
// Port checker for the tone map exchange block
`timescale 1ns/1ps
module tone_map_exchange_monitor
	import tone_map_pkg::*;
(
	input wire logic               i_clk,
	input wire logic               i_rstn,
	input wire logic               i_ce,
	input wire logic               i_tx_valid,
	input wire logic               o_tx_cfg_valid,
	input wire tx_cfg_t            o_tx_cfg,
	input wire logic               i_rx_valid,
	input wire logic [ADDR_W-1:0]  i_rx_src,
	input wire logic               i_rx_tone_map_request_flag,
	input wire logic [2:0]         i_rx_fch_mod,
	input wire logic               o_rx_ready,
	input wire logic [2:0]         o_rx_decode_mod,
	input wire logic               o_rsp_valid,
	input wire logic               i_rsp_ready,
	input wire logic [ADDR_W-1:0]  o_rsp_dest,
	input wire logic               o_rsp_robust,
	input wire logic [95:0]        o_rsp_body
);
	// ------------------------------------------------
	// Properties
	// ------------------------------------------------
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	wire rx_take = i_rx_valid && o_rx_ready; // Frame accepted
	wire rx_flag = i_rx_tone_map_request_flag; // Peer asks
	AST_CFG_LAT: assert property (i_tx_valid && i_ce |=> o_tx_cfg_valid)
		else $error("lookup gave no configuration");
	AST_CFG_ONLY: assert property (!i_tx_valid && i_ce |=> !o_tx_cfg_valid)
		else $error("configuration without a frame");
	AST_REQ_ROBUST: assert property (o_tx_cfg_valid &&
		o_tx_cfg.tone_map_request_flag |-> o_tx_cfg.robust &&
		o_tx_cfg.mod == MOD_ROBUST) else $error("request not robust");
	AST_NO_RESERVED: assert property (o_tx_cfg_valid |-> !o_tx_cfg.mod[2])
		else $error("reserved modulation code");
	AST_RSP_ROBUST: assert property (o_rsp_valid |-> o_rsp_robust)
		else $error("response not robust");
	AST_RSP_ZERO: assert property (o_rsp_valid |-> o_rsp_body[55:0] == 56'h0)
		else $error("coefficient bytes not zero");
	AST_NO_RSP_CLEAR: assert property (rx_take && !rx_flag |=> !o_rsp_valid)
		else $error("response without request");
	AST_RSP_SOON: assert property (rx_take && rx_flag |=> o_rsp_valid &&
		o_rsp_dest == $past(i_rx_src)) else $error("response late or misaddressed");
	AST_RSP_HOLD: assert property (o_rsp_valid && !i_rsp_ready && i_ce
		|=> o_rsp_valid && $stable(o_rsp_body)) else $error("response dropped");
	AST_DECODE: assert property (rx_take |=> o_rx_decode_mod == $past(i_rx_fch_mod))
		else $error("decode modulation wrong");
	// Main scenarios reached
	cover property (rx_take && rx_flag);
	cover property (o_rsp_valid && !i_rsp_ready);
	cover property (o_tx_cfg_valid && !o_tx_cfg.tone_map_request_flag);
endmodule : tone_map_exchange_monitor
bind tone_map_exchange tone_map_exchange_monitor i_tone_map_exchange_monitor (
	.i_clk, .i_rstn, .i_ce, .i_tx_valid, .o_tx_cfg_valid, .o_tx_cfg,
	.i_rx_valid, .i_rx_src, .i_rx_tone_map_request_flag, .i_rx_fch_mod,
	.o_rx_ready, .o_rx_decode_mod, .o_rsp_valid, .i_rsp_ready, .o_rsp_dest,
	.o_rsp_robust, .o_rsp_body);

// [sim/tone_map_peer_model.sv]
// Peer modem model across the line
`timescale 1ns/1ps
module tone_map_peer_model
	import tone_map_pkg::*;
(
	input  wire logic               i_clk,
	input  wire logic               i_rstn,
	input  wire logic               i_cfg_valid,
	input  wire tx_cfg_t            i_cfg,
	input  wire logic [ADDR_W-1:0]  i_dest,
	input  wire logic               i_mute,
	input  wire logic               i_slow,
	input  wire logic [95:0]        i_body,
	input  wire logic               i_rsp_valid,
	output logic                    o_rsp_ready,
	output logic                    o_in_valid,
	output logic [ADDR_W-1:0]       o_in_src,
	output logic [95:0]             o_in_body
);
	logic [1:0]        wait_q; // Cycles left before our answer
	logic [2:0]        hold_q; // Cycles the block's answer waited
	logic [ADDR_W-1:0] src_q;  // Who asked
	// Answer a request unless told to stay silent; another request before the answer restarts the wait
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			wait_q <= 2'h0;
		else if (i_cfg_valid && i_cfg.tone_map_request_flag && !i_mute)
			wait_q <= 2'h3;
		else if (wait_q != 2'h0)
			wait_q <= wait_q - 2'h1;
	end
	// Remember the requester
	always_ff @(posedge i_clk)
		if (i_cfg_valid)
			src_q <= i_dest;
	// Idle lines carry garbage so a stale value never passes
	assign o_in_valid = (wait_q == 2'h1);
	assign o_in_src = o_in_valid ? src_q : ~src_q;
	assign o_in_body = o_in_valid ? i_body : ~i_body;
	// Slow mode makes the block hold its answer
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn || !i_rsp_valid)
			hold_q <= 3'h0;
		else if (hold_q != 3'h7)
			hold_q <= hold_q + 3'h1;
	end
	assign o_rsp_ready = !i_slow || hold_q >= 3'h4;
endmodule : tone_map_peer_model
